// ==== include/scfg_consts.svh ====
// offsets, field positions, reset values and protocol figures of the
// serializer configuration bank; assumes nothing beyond a preprocessor
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define SCFG_OFF_GENERAL_INPUT_LEVELS 8'h05
`define SCFG_OFF_GENERAL_OUTPUT_LEVELS 8'h06
`define SCFG_OFF_EMPH 8'h20
`define SCFG_OFF_FEAT 8'h21
`define SCFG_OFF_UNLOCK 8'h22
`define SCFG_OFF_DELAY 8'h24

// ---------------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------------
`define SCFG_RST_BYTE 8'h00
`define SCFG_EMPH_SEL 2
`define SCFG_FEAT_NRZI 7
`define SCFG_FEAT_WVS 6
`define SCFG_FEAT_SCR 4
`define SCFG_FEAT_BYP 3
`define SCFG_FEAT_TRN 2
`define SCFG_FEAT_RS 1
`define SCFG_FEAT_ENC 0
`define SCFG_UNL_NRZI 4
`define SCFG_UNL_SCR 3
`define SCFG_UNL_BYP 2
`define SCFG_UNL_TRN 1
`define SCFG_UNL_PIN 0
`define SCFG_DELAY_BYP 7

// ---------------------------------------------------------------------------
// serial management port
// ---------------------------------------------------------------------------
`define SCFG_DEV_ADDR 7'h57
`define SCFG_BITS_PER_BYTE 4'h8

`endif

// ==== include/scfg_pkg.sv ====
// types shared by the configuration bank and its serial front end
// assumes scfg_consts.svh is on the include path
package scfg_pkg;

  // serial management port byte engine
  typedef enum logic [3:0] {
    SCFG_IDLE, SCFG_ADDR, SCFG_ADDR_ACK, SCFG_CMD, SCFG_CMD_ACK,
    SCFG_WDATA, SCFG_WR_ACK, SCFG_RDATA, SCFG_RD_ACK
  } scfg_state_e;

  // front end state: synchronisers plus byte engine
  typedef struct packed {
    scfg_state_e state;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_o;
    logic sda_oe;
    logic wr_en;
    logic [7:0] wr_data;
  } scfg_front_s;

  // register bank state: stored fields plus registered effective settings
  typedef struct packed {
    logic [2:0] general_output_levels;
    logic [2:0] emph;
    logic [7:0] feat;
    logic [4:0] unlock;
    logic delay_byp;
    logic [1:0] emph_eff;
    logic nrzi_eff;
    logic rs_n_eff;
    logic enc_n_eff;
  } scfg_bank_s;

endpackage : scfg_pkg

// ==== include/scfg_reg_if.sv ====
// register access path between the serial front end and the bank
// assumes one clock shared by both ends
interface scfg_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output wr_en, output addr, output wdata, input rdata);
  modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface : scfg_reg_if

// ==== src/scfg_bank.sv ====
// configuration register bank with unlock gating and pin/register select
// assumes pin levels arrive already synchronised to clock
`include "scfg_consts.svh"

module scfg_bank (
  input wire logic clock,
  input wire logic rstn,
  scfg_reg_if.bank bus,
  input wire logic [2:0] general_input_levels,
  input wire logic [1:0] emph_pins,
  input wire logic rs_pin_n,
  input wire logic enc_pin_n,
  output logic [2:0] general_output_levels,
  output logic [1:0] emph_level,
  output logic nrzi_enable,
  output logic word_valid_suppress,
  output logic scrambler_enable,
  output logic encoder_bypass,
  output logic training_enable,
  output logic remote_sense_n,
  output logic encoder_enable_n,
  output logic clock_delay_bypass
);

  scfg_pkg::scfg_bank_s st;
  scfg_pkg::scfg_bank_s next_st;

  // ---------------------------------------------------------------------------
  // next state: writes and effective settings
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.emph_eff = st.emph[`SCFG_EMPH_SEL] ? st.emph[1:0] : emph_pins;
    next_st.nrzi_eff = st.feat[`SCFG_FEAT_NRZI] & st.unlock[`SCFG_UNL_NRZI];
    next_st.rs_n_eff = st.unlock[`SCFG_UNL_PIN] ? st.feat[`SCFG_FEAT_RS] : rs_pin_n;
    next_st.enc_n_eff = st.unlock[`SCFG_UNL_PIN] ? st.feat[`SCFG_FEAT_ENC] : enc_pin_n;
    if (bus.wr_en) begin
      case (bus.addr)
        `SCFG_OFF_GENERAL_OUTPUT_LEVELS: next_st.general_output_levels = bus.wdata[2:0];
        `SCFG_OFF_EMPH: next_st.emph = bus.wdata[2:0];
        `SCFG_OFF_FEAT: begin
          // locked bits keep their old value, host must unlock first
          next_st.feat[6:5] = bus.wdata[6:5];
          if (st.unlock[`SCFG_UNL_NRZI]) next_st.feat[7] = bus.wdata[7];
          if (st.unlock[`SCFG_UNL_SCR]) next_st.feat[4] = bus.wdata[4];
          if (st.unlock[`SCFG_UNL_BYP]) next_st.feat[3] = bus.wdata[3];
          if (st.unlock[`SCFG_UNL_TRN]) next_st.feat[2] = bus.wdata[2];
          if (st.unlock[`SCFG_UNL_PIN]) next_st.feat[1:0] = bus.wdata[1:0];
        end
        `SCFG_OFF_UNLOCK: next_st.unlock = bus.wdata[4:0];
        `SCFG_OFF_DELAY: next_st.delay_byp = bus.wdata[`SCFG_DELAY_BYP];
        default: ;
      endcase
    end
  end

  // state register, everything clears to zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // read mux, unmapped and reserved bits read zero, except feat bit 5, which reads back as written
  // ---------------------------------------------------------------------------
  always_comb begin
    case (bus.addr)
      `SCFG_OFF_GENERAL_INPUT_LEVELS: bus.rdata = {5'h00, general_input_levels};
      `SCFG_OFF_GENERAL_OUTPUT_LEVELS: bus.rdata = {5'h00, st.general_output_levels};
      `SCFG_OFF_EMPH: bus.rdata = {5'h00, st.emph};
      `SCFG_OFF_FEAT: bus.rdata = st.feat;
      `SCFG_OFF_UNLOCK: bus.rdata = {3'h0, st.unlock};
      `SCFG_OFF_DELAY: bus.rdata = {st.delay_byp, 7'h00};
      default: bus.rdata = `SCFG_RST_BYTE;
    endcase
  end

  // outputs all come from the state register
  assign general_output_levels = st.general_output_levels;
  assign emph_level = st.emph_eff;
  assign nrzi_enable = st.nrzi_eff;
  assign word_valid_suppress = st.feat[`SCFG_FEAT_WVS];
  assign scrambler_enable = st.feat[`SCFG_FEAT_SCR];
  assign encoder_bypass = st.feat[`SCFG_FEAT_BYP];
  assign training_enable = st.feat[`SCFG_FEAT_TRN];
  assign remote_sense_n = st.rs_n_eff;
  assign encoder_enable_n = st.enc_n_eff;
  assign clock_delay_bypass = st.delay_byp;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_general_output_levels;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_GENERAL_OUTPUT_LEVELS) |=> general_output_levels == $past(bus.wdata[2:0]);
  endproperty
  a_general_output_levels: assert property (p_general_output_levels) else $error("general_output_levels not written");

  property p_emph_pin;
    @(posedge clock) disable iff (!rstn)
    (!st.emph[`SCFG_EMPH_SEL] && $stable(emph_pins)) |=> emph_level == $past(emph_pins);
  endproperty
  a_emph_pin: assert property (p_emph_pin) else $error("emphasis not from pins");

  property p_emph_reg;
    @(posedge clock) disable iff (!rstn)
    (st.emph[`SCFG_EMPH_SEL] && $stable(st.emph)) |=> emph_level == $past(st.emph[1:0]);
  endproperty
  a_emph_reg: assert property (p_emph_reg) else $error("emphasis not from register");

  property p_nrzi;
    @(posedge clock) disable iff (!rstn)
    !st.unlock[`SCFG_UNL_NRZI] |=> !nrzi_enable;
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi active while locked");

  property p_wvs;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_FEAT) |=> word_valid_suppress == $past(bus.wdata[6]);
  endproperty
  a_wvs: assert property (p_wvs) else $error("valid suppress not written");

  property p_scr_lock;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_FEAT && !st.unlock[`SCFG_UNL_SCR]) |=> $stable(scrambler_enable);
  endproperty
  a_scr_lock: assert property (p_scr_lock) else $error("scrambler changed while locked");

  property p_byp_lock;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_FEAT && !st.unlock[`SCFG_UNL_BYP]) |=> $stable(encoder_bypass);
  endproperty
  a_byp_lock: assert property (p_byp_lock) else $error("bypass changed while locked");

  property p_trn_open;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_FEAT && st.unlock[`SCFG_UNL_TRN]) |=> training_enable == $past(bus.wdata[2]);
  endproperty
  a_trn_open: assert property (p_trn_open) else $error("training write lost");

  property p_rs_pin;
    @(posedge clock) disable iff (!rstn)
    (!st.unlock[`SCFG_UNL_PIN] && $stable(rs_pin_n)) |=> remote_sense_n == $past(rs_pin_n);
  endproperty
  a_rs_pin: assert property (p_rs_pin) else $error("remote sense not from pin");

  property p_enc_reg;
    @(posedge clock) disable iff (!rstn)
    (st.unlock[`SCFG_UNL_PIN] && $stable(st.feat)) |=> encoder_enable_n == $past(st.feat[0]);
  endproperty
  a_enc_reg: assert property (p_enc_reg) else $error("encoder enable not from register");

  property p_delay;
    @(posedge clock) disable iff (!rstn)
    (bus.wr_en && bus.addr == `SCFG_OFF_DELAY) |=> clock_delay_bypass == $past(bus.wdata[7]);
  endproperty
  a_delay: assert property (p_delay) else $error("delay bypass not written");

endmodule : scfg_bank

// ==== src/scfg_top.sv ====
// serializer configuration bank behind its two-wire management port
// assumes the host follows the byte-read and byte-write framing, no clock
// stretching is ever needed, and pins are asynchronous to clock
`include "scfg_consts.svh"

module scfg_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic smbus_clock,
  input wire logic smbus_data_in,
  output logic smbus_data_out,
  output logic smbus_data_oe,
  input wire logic general_pin_zero_in,
  input wire logic general_pin_one_in,
  input wire logic general_pin_two_in,
  output logic general_pin_zero_out,
  output logic general_pin_one_out,
  output logic general_pin_two_out,
  input wire logic [1:0] emphasis_pins,
  input wire logic remote_sense_pin_n,
  input wire logic encoder_enable_pin_n,
  output logic [1:0] emphasis_level,
  output logic nrzi_enable,
  output logic word_valid_suppress,
  output logic scrambler_enable,
  output logic encoder_bypass,
  output logic training_enable,
  output logic remote_sense_n,
  output logic encoder_enable_n,
  output logic clock_delay_bypass
);

  scfg_pkg::scfg_front_s st;
  scfg_pkg::scfg_front_s next_st;
  scfg_reg_if bus ();
  logic [2:0] gp_level;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // ---------------------------------------------------------------------------
  // line events, seen only past the second synchroniser stage
  // ---------------------------------------------------------------------------
  assign scl_rise = st.scl_s2 & ~st.scl_s3;
  assign scl_fall = ~st.scl_s2 & st.scl_s3;
  // each mark lags the line by two clocks, which is why the host
  // has to hold every line level for five clocks or more
  // data moves only while the clock line is low, so these are framing marks
  assign bus_start = st.scl_s2 & st.scl_s3 & st.sda_s3 & ~st.sda_s2;
  assign bus_stop = st.scl_s2 & st.scl_s3 & ~st.sda_s3 & st.sda_s2;

  // ---------------------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    next_st.sda_o = 1'b0;
    next_st.scl_s1 = smbus_clock;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_s3 = st.scl_s2;
    next_st.sda_s1 = smbus_data_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_s3 = st.sda_s2;
    next_st.pin_s1 = {encoder_enable_pin_n, remote_sense_pin_n, emphasis_pins,
                      general_pin_two_in, general_pin_one_in, general_pin_zero_in};
    next_st.pin_s2 = st.pin_s1;
    // a strap moving during a sample settles one clock later, harmless for levels
    if (bus_start) begin
      // a repeated start restarts framing from any state
      next_st.state = scfg_pkg::SCFG_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st.state = scfg_pkg::SCFG_IDLE;
      next_st.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (st.state)
        scfg_pkg::SCFG_ADDR, scfg_pkg::SCFG_CMD, scfg_pkg::SCFG_WDATA: begin
          next_st.shift = {st.shift[6:0], st.sda_s2};
          next_st.cnt = st.cnt + 4'h1;
        end
        scfg_pkg::SCFG_RDATA: next_st.cnt = st.cnt + 4'h1;
        scfg_pkg::SCFG_RD_ACK: begin
          // host ack asks for the next byte, so step the pointer now
          next_st.mack = ~st.sda_s2;
          if (!st.sda_s2) next_st.ptr = st.ptr + 8'h01;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st.state)
        scfg_pkg::SCFG_ADDR: begin
          if (st.cnt == `SCFG_BITS_PER_BYTE) begin
            if (st.shift[7:1] == `SCFG_DEV_ADDR) begin
              next_st.rw = st.shift[0];
              next_st.sda_oe = 1'b1;
              next_st.state = scfg_pkg::SCFG_ADDR_ACK;
            end else begin
              next_st.state = scfg_pkg::SCFG_IDLE;
            end
          end
        end
        scfg_pkg::SCFG_CMD: begin
          if (st.cnt == `SCFG_BITS_PER_BYTE) begin
            next_st.ptr = st.shift;
            next_st.sda_oe = 1'b1;
            next_st.state = scfg_pkg::SCFG_CMD_ACK;
          end
        end
        scfg_pkg::SCFG_WDATA: begin
          if (st.cnt == `SCFG_BITS_PER_BYTE) begin
            next_st.wr_en = 1'b1;
            next_st.wr_data = st.shift;
            next_st.sda_oe = 1'b1;
            next_st.state = scfg_pkg::SCFG_WR_ACK;
          end
        end
        scfg_pkg::SCFG_ADDR_ACK: begin
          next_st.cnt = 4'h0;
          if (st.rw) begin
            next_st.shift = bus.rdata;
            next_st.sda_oe = ~bus.rdata[7];
            next_st.state = scfg_pkg::SCFG_RDATA;
          end else begin
            next_st.sda_oe = 1'b0;
            next_st.state = scfg_pkg::SCFG_CMD;
          end
        end
        scfg_pkg::SCFG_CMD_ACK: begin
          next_st.sda_oe = 1'b0;
          next_st.cnt = 4'h0;
          next_st.state = scfg_pkg::SCFG_WDATA;
        end
        scfg_pkg::SCFG_WR_ACK: begin
          // further bytes of the same frame land at the following offsets
          next_st.sda_oe = 1'b0;
          next_st.cnt = 4'h0;
          next_st.ptr = st.ptr + 8'h01;
          next_st.state = scfg_pkg::SCFG_WDATA;
        end
        scfg_pkg::SCFG_RDATA: begin
          if (st.cnt == `SCFG_BITS_PER_BYTE) begin
            next_st.sda_oe = 1'b0;
            next_st.state = scfg_pkg::SCFG_RD_ACK;
          end else begin
            next_st.shift = {st.shift[6:0], 1'b0};
            next_st.sda_oe = ~st.shift[6];
          end
        end
        scfg_pkg::SCFG_RD_ACK: begin
          if (st.mack) begin
            next_st.shift = bus.rdata;
            next_st.sda_oe = ~bus.rdata[7];
            next_st.cnt = 4'h0;
            next_st.state = scfg_pkg::SCFG_RDATA;
          end else begin
            next_st.state = scfg_pkg::SCFG_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // state register, idle and released after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------------------
  assign bus.wr_en = st.wr_en;
  assign bus.addr = st.ptr;
  assign bus.wdata = st.wr_data;
  assign gp_level = st.pin_s2[2:0];

  scfg_bank u_bank (
    .clock(clock),
    .rstn(rstn),
    .bus(bus),
    .general_input_levels(gp_level),
    .emph_pins(st.pin_s2[4:3]),
    .rs_pin_n(st.pin_s2[5]),
    .enc_pin_n(st.pin_s2[6]),
    .general_output_levels({general_pin_two_out, general_pin_one_out, general_pin_zero_out}),
    .emph_level(emphasis_level),
    .nrzi_enable(nrzi_enable),
    .word_valid_suppress(word_valid_suppress),
    .scrambler_enable(scrambler_enable),
    .encoder_bypass(encoder_bypass),
    .training_enable(training_enable),
    .remote_sense_n(remote_sense_n),
    .encoder_enable_n(encoder_enable_n),
    .clock_delay_bypass(clock_delay_bypass)
  );

  // open-drain data line, only ever pulled low
  assign smbus_data_out = st.sda_o;
  assign smbus_data_oe = st.sda_oe;

  // ---------------------------------------------------------------------------
  // checks and coverage
  // ---------------------------------------------------------------------------
  property p_general_input_levels;
    @(posedge clock) disable iff (!rstn)
    (bus.addr == `SCFG_OFF_GENERAL_INPUT_LEVELS && $stable(st.pin_s1[2:0]) && $stable(st.pin_s2[2:0]))
      |-> bus.rdata == {5'h00, $past(st.pin_s1[2:0])};
  endproperty
  a_general_input_levels: assert property (p_general_input_levels) else $error("input level readback wrong");

  property p_wr_ack;
    @(posedge clock) disable iff (!rstn)
    st.wr_en |-> st.sda_oe && st.state == scfg_pkg::SCFG_WR_ACK;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write without ack");

  // framing marks restart or end the engine from any state
  property p_start;
    @(posedge clock) disable iff (!rstn)
    bus_start |=> st.state == scfg_pkg::SCFG_ADDR && st.cnt == 4'h0 && !smbus_data_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge clock) disable iff (!rstn)
    bus_stop |=> st.state == scfg_pkg::SCFG_IDLE && !smbus_data_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  // only the own address is acknowledged
  property p_addr_ack;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_ADDR && scl_fall && st.cnt == `SCFG_BITS_PER_BYTE)
      |=> smbus_data_oe == ($past(st.shift[7:1]) == `SCFG_DEV_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

  property p_addr_idle;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_ADDR && scl_fall && st.cnt == `SCFG_BITS_PER_BYTE
      && st.shift[7:1] != `SCFG_DEV_ADDR) |=> st.state == scfg_pkg::SCFG_IDLE;
  endproperty
  a_addr_idle: assert property (p_addr_idle) else $error("foreign frame not dropped");

  // ack holds the line low through the whole ninth clock
  property p_ack_hold;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_WR_ACK && !scl_fall && !bus_start && !bus_stop) |=> smbus_data_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");

  // first read bit comes straight from the addressed register
  property p_rd_first;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_ADDR_ACK && scl_fall && st.rw) |=> smbus_data_oe == ~$past(bus.rdata[7]);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first read bit wrong");

  property p_rd_release;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_RDATA && scl_fall && st.cnt == `SCFG_BITS_PER_BYTE) |=> !smbus_data_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("read byte not released");

  // every written byte moves the pointer on by one
  property p_wr_step;
    @(posedge clock) disable iff (!rstn)
    (st.state == scfg_pkg::SCFG_WR_ACK && scl_fall) |=> st.ptr == $past(st.ptr) + 8'h01;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer not stepped");

  c_write: cover property (@(posedge clock) disable iff (!rstn) st.wr_en && bus.addr == `SCFG_OFF_FEAT);
  c_read: cover property (@(posedge clock) disable iff (!rstn) st.state == scfg_pkg::SCFG_RD_ACK && scl_fall);
  c_unlock: cover property (@(posedge clock) disable iff (!rstn) st.wr_en && bus.addr == `SCFG_OFF_UNLOCK);
  c_restart: cover property (@(posedge clock) disable iff (!rstn) bus_start && st.state == scfg_pkg::SCFG_WDATA);
  c_nack: cover property (@(posedge clock) disable iff (!rstn)
    st.state == scfg_pkg::SCFG_ADDR && scl_fall && st.cnt == `SCFG_BITS_PER_BYTE && !next_st.sda_oe);

endmodule : scfg_top

// ==== sim/scfg_host.sv ====
// two-wire management host model for the serializer bank
// assumes a pull-up on the data line and the core clock to pace bits
`include "scfg_consts.svh"
module scfg_host (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // line primitives
  // ----------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // eight clocks a half bit, margin over the five-clock minimum
  task automatic half();
    repeat (8) @(posedge clock);
    #1;
  endtask : half
  // also serves as repeated start while the clock line is low
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // data set while clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    s = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put
  task automatic get(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask : get
  // ----------------
  // register cycles
  // ----------------
  task automatic wr(input logic [7:0] off, input logic [23:0] d, input int n, output logic ok);
    logic a;
    start();
    put({`SCFG_DEV_ADDR, 1'b0}, ok);
    put(off, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      put(d[23-8*i -: 8], a);
      ok &= a;
    end
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] off, input int n, output logic [23:0] q, output logic ok);
    logic a;
    logic [7:0] b;
    q = 24'h00_0000;
    start();
    put({`SCFG_DEV_ADDR, 1'b0}, ok);
    put(off, a);
    ok &= a;
    start();
    put({`SCFG_DEV_ADDR, 1'b1}, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      get(i < n - 1, b);
      q[23-8*i -: 8] = b;
    end
    stop();
  endtask : rd
endmodule : scfg_host

// ==== sim/serializer_config_registers_tb_top.sv ====
// self-checking bench for the serializer configuration bank
// assumes scfg_host as partner and a pull-up on the data line
`include "scfg_consts.svh"
module serializer_config_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic scl, host_low, sda_out, sda_oe, sda;
  logic [2:0] gpi = 3'h0;
  logic [2:0] gpo;
  logic [1:0] epins = 2'h0;
  logic rs_pin_n = 1'b0;
  logic enc_pin_n = 1'b0;
  logic [1:0] elevel;
  logic nrzi, wvs, scr, byp, trn, rs_n, enc_n, dly;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] mreg [256];
  logic [7:0] offs [7] = '{8'h05, 8'h06, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  always #10 clock = ~clock;
  // wired-and data line, released means pulled up
  assign sda = ~host_low & ~(sda_oe & ~sda_out);
  scfg_host host (.clock(clock), .sda_line(sda), .scl(scl), .sda_low(host_low));
  scfg_top dut (.clock(clock), .rstn(rstn), .smbus_clock(scl), .smbus_data_in(sda),
    .smbus_data_out(sda_out), .smbus_data_oe(sda_oe), .general_pin_zero_in(gpi[0]),
    .general_pin_one_in(gpi[1]), .general_pin_two_in(gpi[2]), .general_pin_zero_out(gpo[0]),
    .general_pin_one_out(gpo[1]), .general_pin_two_out(gpo[2]), .emphasis_pins(epins),
    .remote_sense_pin_n(rs_pin_n), .encoder_enable_pin_n(enc_pin_n), .emphasis_level(elevel),
    .nrzi_enable(nrzi), .word_valid_suppress(wvs), .scrambler_enable(scr), .encoder_bypass(byp),
    .training_enable(trn), .remote_sense_n(rs_n), .encoder_enable_n(enc_n), .clock_delay_bypass(dly));
  // ----------------
  // reference model
  // ----------------
  // locked feature bits keep their old value
  function automatic void mwr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    case (a)
      `SCFG_OFF_GENERAL_OUTPUT_LEVELS: m = 8'h07;
      `SCFG_OFF_EMPH: m = 8'h07;
      `SCFG_OFF_FEAT: m = {mreg[8'h22][4], 2'b11, mreg[8'h22][3:1], {2{mreg[8'h22][0]}}};
      `SCFG_OFF_UNLOCK: m = 8'h1f;
      `SCFG_OFF_DELAY: m = 8'h80;
      default: m = 8'h00;
    endcase
    mreg[a] = (mreg[a] & ~m) | (d & m);
  endfunction : mwr
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return (a == `SCFG_OFF_GENERAL_INPUT_LEVELS) ? {5'h00, gpi} : mreg[a];
  endfunction : exp_rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [23:0] d, input int n);
    logic ok;
    host.wr(a, d, n, ok);
    chk(ok, 1'b1);
    for (int i = 0; i < n; i++) mwr(a + 8'(i), d[23-8*i -: 8]);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input int n);
    logic ok;
    logic [23:0] q;
    host.rd(a, n, q, ok);
    chk(ok, 1'b1);
    for (int i = 0; i < n; i++) chk(q[23-8*i -: 8], exp_rd(a + 8'(i)));
  endtask : rreg
  // effective settings need a few clocks after the last change
  task automatic chk_out();
    logic [7:0] f, u;
    f = mreg[8'h21];
    u = mreg[8'h22];
    repeat (4) @(posedge clock);
    #1;
    chk(gpo, mreg[8'h06][2:0]);
    chk(elevel, mreg[8'h20][2] ? mreg[8'h20][1:0] : epins);
    chk(nrzi, f[7] & u[4]);
    chk(wvs, f[6]);
    chk({scr, byp, trn}, f[4:2]);
    chk({rs_n, enc_n}, u[0] ? f[1:0] : {rs_pin_n, enc_pin_n});
    chk(dly, mreg[8'h24][7]);
  endtask : chk_out
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ----------------
  // tests
  // ----------------
  initial begin
    logic [7:0] a, d;
    logic ok;
    foreach (mreg[i]) mreg[i] = 8'h00;
    void'($urandom(32'hfd37_2c88));
    repeat (3) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clock);
    foreach (offs[i]) rreg(offs[i], 1);
    chk_out();
    $display("test reset done");
    // foreign address must stay unanswered
    host.start();
    host.put(8'h2a, ok);
    chk(ok, 1'b0);
    host.put(8'h06, ok);
    host.put(8'h07, ok);
    host.stop();
    rreg(8'h06, 1);
    $display("test address done");
    // gated write while locked, then unlock and retry
    wreg(8'h21, 24'hfc_0000, 1);
    rreg(8'h21, 1);
    chk_out();
    wreg(8'h22, 24'h1f_0080, 3);
    wreg(8'h20, 24'h06_0000, 1);
    wreg(8'h06, 24'h05_0000, 1);
    wreg(8'h21, 24'hff_0000, 1);
    rreg(8'h20, 3);
    chk_out();
    wreg(8'h22, 24'h00_0000, 1);
    chk_out();
    $display("test unlock done");
    for (int k = 0; k < 20; k++) begin
      {gpi, epins, rs_pin_n, enc_pin_n} = 7'($urandom());
      a = offs[$urandom_range(6)];
      d = 8'($urandom());
      if (a == 8'h21 && !mreg[8'h22][0]) d[1:0] = mreg[8'h21][1:0];
      wreg(a, {d, 16'h0000}, 1);
      rreg(a, 2);
      chk_out();
    end
    $display("test random done");
    summarize();
  end
  // whole run needs under a millisecond, so this leaves half a millisecond of margin
  initial begin
    #1500us;
    n_errors++;
    $display("watchdog expired");
    summarize();
  end
endmodule : serializer_config_registers_tb_top
